/* File: wdt_pkg.sv */
// Behaviour
// - writing one to the strobe bit reloads the counter from the timeout field and restarts, or goes idle when the field is zero.
// - writing zero to the strobe bit changes nothing in the watchdog.
// - the strobe bit clears itself once the reload has been done.
// - the strobe bit is write-only and always reads as zero.
// - while the write-lock bit is one, writes to the timeout field are ignored.
// - with the write-lock bit zero, the timeout field takes the written value.
// - timeout equals field value times one 32 Hz tick of 31.25 ms.
package wdt_pkg;
    localparam logic [7:0] WATCHDOG_CONTROL_IDX = 8'h07;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h10;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h11;
    localparam logic [7:0] COUNT_STATUS_IDX = 8'h12;
    localparam int STROBE_BIT = 7;
    localparam int LOCK_BIT = 6;
    localparam int FIELD_W = 6;
    localparam logic [5:0] TIMEOUT_RESET = 6'h00;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_HZ = 32;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam logic [7:0] EVT_TIMEOUT_BIT = 8'h01;

    typedef struct packed {
        logic lock;
        logic [5:0] field;
    } wd_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_EXPIRED = 2'b10
    } wd_state_t;
endpackage : wdt_pkg

/* File: tick_divider.sv */
module tick_divider
    import wdt_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    output logic tick
);
    logic [31:0] count;

    // restart aligns the tick phase so a reload gives a full first period
    always_ff @(posedge clk) begin
        if (!rst_b || restart) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : tick_divider

/* File: watchdog_timer_control.sv */
module watchdog_timer_control
    import wdt_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [9:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic ERR_O,
    output logic IRQ,
    output logic WD_TIMEOUT
);
    wd_cfg_t cfg;
    wd_state_t state;
    logic strobe_pending;
    logic [5:0] remaining;
    logic tick;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic req;
    logic mapped;
    logic wr;
    logic [7:0] idx;
    logic expire;

    function automatic logic addr_is(input logic [9:0] a, input logic [7:0] i);
        return a[9:2] == i && a[1:0] == 2'b00;
    endfunction : addr_is

    assign req = CYC_I && STB_I && !ACK_O && !ERR_O;
    assign idx = ADR_I[9:2];
    assign mapped = addr_is(ADR_I, WATCHDOG_CONTROL_IDX) || addr_is(ADR_I, IRQ_STATUS_IDX)
        || addr_is(ADR_I, IRQ_MASK_IDX) || addr_is(ADR_I, COUNT_STATUS_IDX);
    assign wr = req && WE_I && SEL_I[0] && mapped;

    // one-cycle ack; unmapped addresses answer with err
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            ACK_O <= 1'b0;
            ERR_O <= 1'b0;
        end else begin
            ACK_O <= req && mapped;
            ERR_O <= req && !mapped;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            DAT_O <= 32'h0;
        end else if (req && !WE_I) begin
            case (idx)
                // strobe position always reads zero
                WATCHDOG_CONTROL_IDX: DAT_O <= {24'h0, 1'b0, cfg.lock, cfg.field};
                IRQ_STATUS_IDX: DAT_O <= {24'h0, irq_status};
                IRQ_MASK_IDX: DAT_O <= {24'h0, irq_mask};
                COUNT_STATUS_IDX: DAT_O <= {24'h0, state, remaining};
                default: DAT_O <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            cfg <= '{lock: 1'b0, field: TIMEOUT_RESET};
        end else if (wr && idx == WATCHDOG_CONTROL_IDX) begin
            cfg.lock <= DAT_I[LOCK_BIT];
            // lock as it stood before this write gates the field
            if (!cfg.lock) begin
                cfg.field <= DAT_I[FIELD_W-1:0];
            end
        end
    end

    // a write of zero leaves the pending strobe alone
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            strobe_pending <= 1'b0;
        end else if (wr && idx == WATCHDOG_CONTROL_IDX && DAT_I[STROBE_BIT]) begin
            strobe_pending <= 1'b1;
        end else if (strobe_pending) begin
            strobe_pending <= 1'b0;
        end
    end

    tick_divider #(
        .CYCLES(TICK_DIV)
    ) u_tick (
        .clk(MCLK),
        .rst_b(RST_B),
        .restart(strobe_pending),
        .tick(tick)
    );

    assign expire = state == ST_RUN && tick && remaining == 6'h01;

    // idle until the first strobe; a zero field never arms the counter
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            state <= ST_IDLE;
            remaining <= 6'h00;
        end else if (strobe_pending) begin
            remaining <= cfg.field;
            state <= (cfg.field == 6'h00) ? ST_IDLE : ST_RUN;
        end else begin
            case (state)
                ST_IDLE: state <= ST_IDLE;
                ST_RUN: begin
                    if (tick) begin
                        remaining <= remaining - 6'h01;
                        if (expire) begin
                            state <= ST_EXPIRED;
                        end
                    end
                end
                ST_EXPIRED: state <= ST_EXPIRED;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            WD_TIMEOUT <= 1'b0;
        end else begin
            WD_TIMEOUT <= expire;
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            irq_status <= 8'h00;
        end else begin
            if (wr && idx == IRQ_STATUS_IDX) begin
                irq_status <= irq_status & ~DAT_I[7:0] & EVT_TIMEOUT_BIT;
            end
            if (expire) begin
                irq_status[0] <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            irq_mask <= 8'h00;
        end else if (wr && idx == IRQ_MASK_IDX) begin
            irq_mask <= DAT_I[7:0] & EVT_TIMEOUT_BIT;
        end
    end

    assign IRQ = |(irq_status & irq_mask);
endmodule : watchdog_timer_control

/* File: wdt_monitor.sv */
module wdt_monitor #(parameter int TICK_DIV = 8) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [9:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic ERR_O,
    input wire logic IRQ,
    input wire logic WD_TIMEOUT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    property p_ack; ACK_O |=> !ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("long ack");
    property p_req; ACK_O || ERR_O |-> $past(CYC_I && STB_I); endproperty
    a_req: assert property (p_req) else $error("stray answer");
    property p_one; !(ACK_O && ERR_O); endproperty
    a_one: assert property (p_one) else $error("ack and err");
    property p_wo; ACK_O && $past(!WE_I && ADR_I == 10'h1c) |-> !DAT_O[7]; endproperty
    a_wo: assert property (p_wo) else $error("strobe read");
    property p_err; ERR_O |-> $past(ADR_I) != 10'h1c; endproperty
    a_err: assert property (p_err) else $error("err on control");
    property p_to; WD_TIMEOUT |=> !WD_TIMEOUT; endproperty
    a_to: assert property (p_to) else $error("long expiry");
    // an old run may still expire before the reload lands
    property p_rs; ACK_O && $past(WE_I && SEL_I[0] && DAT_I[7] && ADR_I == 10'h1c)
        |-> ##2 !WD_TIMEOUT [*6]; endproperty
    a_rs: assert property (p_rs) else $error("early expiry");
    property p_clr; ACK_O && !WD_TIMEOUT && $past(WE_I && SEL_I[0] && DAT_I[0]
        && ADR_I == 10'h40 && !WD_TIMEOUT) |-> !IRQ; endproperty
    a_clr: assert property (p_clr) else $error("irq stuck");
endmodule : wdt_monitor
bind watchdog_timer_control wdt_monitor #(.TICK_DIV(TICK_DIV)) u_mon (.*);

/* File: tb_watchdog_timer_control.sv */
module tb_watchdog_timer_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 8;
    logic clk = 0, rst_b = 0, cyc = 0, we = 0, e, ack, err, irq, tmo;
    logic [9:0] adr = 0;
    logic [7:0] d = 0, x, m = 8'h00;
    logic [3:0] sel = 4'h1, s = 4'h1;
    logic [31:0] q, dat_o;
    int err_total = 0, n_checks = 0, n;
    always #25 clk = ~clk;
    watchdog_timer_control #(.TICK_DIV(TK)) dut_u (.MCLK(clk), .RST_B(rst_b), .CYC_I(cyc),
        .STB_I(cyc), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I({24'h0, d}),
        .DAT_O(dat_o), .ACK_O(ack), .ERR_O(err), .IRQ(irq), .WD_TIMEOUT(tmo));
    task chk(input logic [31:0] g, w);
        n_checks++;
        if (g !== w) begin
            err_total++;
            $display("CHECK FAILED t=%0t %h/%h", $time, g, w);
        end
    endtask : chk
    // control readback: strobe reads zero, field held while the stored lock is set
    function automatic logic [7:0] ctl_model(input logic [7:0] c, input logic [7:0] v);
        return {1'b0, v[6], c[6] ? c[5:0] : v[5:0]};
    endfunction : ctl_model
    task wb(input logic [9:0] a, input logic w, input logic [7:0] v);
        @(posedge clk);
        cyc <= 1;
        we <= w;
        sel <= s;
        adr <= a;
        d <= v;
        @(posedge clk);
        while (ack !== 1 && err !== 1) @(posedge clk);
        q = dat_o;
        e = err;
        cyc <= 0;
    endtask : wb
    // edges from the restart ack to the sampled pulse: registered pulse plus the edge at which it is sampled
    task wt(input int t);
        n = 0;
        while (tmo !== 1) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n), 32'(t + 2));
    endtask : wt
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        end_of_test();
    end
    initial begin
        void'($urandom(77));
        repeat (4) @(posedge clk);
        rst_b <= 1;
        wb(10'h1c, 0, 0);
        chk(q, 32'h0);
        repeat (6) begin
            x = 8'($urandom);
            wb(10'h1c, 1, x);
            m = ctl_model(m, x);
            wb(10'h1c, 0, 0);
            chk(q, 32'(m));
        end
        // park the counter and drop any expiry left by the random strobes
        wb(10'h1c, 1, 8'h00);
        wb(10'h1c, 1, 8'h80);
        wb(10'h40, 1, 1);
        wb(10'h44, 1, 1);
        chk(irq, 0);
        wb(10'h1c, 1, 8'h85);
        wt(5 * TK);
        @(posedge clk);
        chk(irq, 1);
        wb(10'h40, 1, 1);
        chk(irq, 0);
        wb(10'h1c, 1, 8'h49);
        wb(10'h1c, 1, 8'h62);
        wb(10'h1c, 0, 0);
        chk(q, 32'h49);
        wb(10'h1c, 1, 8'h9f);
        wt(9 * TK);
        wb(10'h1c, 1, 8'h83);
        repeat (10) @(posedge clk);
        wb(10'h1c, 1, 8'h3f);
        wt(3 * TK - 13);
        wb(10'h3fc, 0, 0);
        chk(e, 1);
        s = 4'h2;
        wb(10'h1c, 1, 8'ha1);
        s = 4'h1;
        wb(10'h1c, 0, 0);
        chk(q, 32'h3f);
        wb(10'h48, 0, 0);
        chk(q, 32'h80);
        // reset in mid-run drops the armed counter and the settings
        wb(10'h1c, 1, 8'h82);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        wb(10'h1c, 0, 0);
        chk(q, 32'h0);
        wb(10'h48, 0, 0);
        chk(q, 32'h0);
        end_of_test();
    end
endmodule : tb_watchdog_timer_control
